/* File: i2c_master_sequencer_regs.svh */
`ifndef I2C_MASTER_SEQUENCER_REGS_SVH
`define I2C_MASTER_SEQUENCER_REGS_SVH

// system clock period and instruction cycle, in ns
`define CLOCK_PERIOD_NS 10
`define INSTRUCTION_CYCLE_NS 80

// baud counter decrements twice per instruction cycle
`define HALF_INSTRUCTION_CLKS 3'((`INSTRUCTION_CYCLE_NS / `CLOCK_PERIOD_NS) / 2)

// late buffer writes within this many instruction cycles still land
`define COLLISION_WINDOW_CYCLES 2
`define COLLISION_WINDOW_CLKS \
	5'((`COLLISION_WINDOW_CYCLES * `INSTRUCTION_CYCLE_NS) / `CLOCK_PERIOD_NS)

// reload field width, bit counts of a byte
`define RELOAD_WIDTH 7
`define LAST_DATA_BIT 4'h7
`define ACK_BIT 4'h8

`endif

/* File: i2c_seq_pkg.sv */
package i2c_seq_pkg;

	typedef enum logic [3:0] {
		IDLE = 4'b0000,
		START_WAIT = 4'b0001,
		START_HOLD = 4'b0010,
		REPEAT_CLOCK_LOW = 4'b0011,
		REPEAT_DATA_RELEASE = 4'b0100,
		REPEAT_CLOCK_RELEASE = 4'b0101,
		REPEAT_BOTH_HIGH = 4'b0110,
		REPEAT_DATA_LOW = 4'b0111,
		TX_LOW = 4'b1000,
		TX_HIGH_WAIT = 4'b1001,
		TX_HIGH = 4'b1010,
		RX_LOW = 4'b1011,
		RX_HIGH_WAIT = 4'b1100,
		RX_HIGH = 4'b1101,
		RX_PUSH = 4'b1110
	} seq_state_e;

	typedef struct packed {
		seq_state_e state;
		logic [6:0] baud_counter;
		logic [2:0] phase;
		logic [3:0] bit_count;
		logic [4:0] write_age;
		logic [7:0] shift_register;
		logic [7:0] transfer_buffer;
		logic clock_sync_a;
		logic clock_sync_b;
		logic data_sync_a;
		logic data_sync_b;
		logic data_prev;
		logic clock_oe;
		logic data_oe;
		logic begin_request_bit;
		logic repeat_begin_request_bit;
		logic receive_request_bit;
		logic buffer_full_flag;
		logic write_collision_flag;
		logic bus_collision_flag;
		logic port_interrupt_flag;
		logic ack_received_status;
		logic receive_overrun_flag;
		logic start_detected;
		logic push;
		logic busy;
	} seq_s;

	typedef struct packed {
		logic [1:0][7:0] data;
		logic [1:0] valid;
		logic room;
	} pair_s;

endpackage : i2c_seq_pkg

/* File: byte_pair_buffer.sv */
`timescale 1ns/100ps
module byte_pair_buffer (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clock_enable,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [7:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [7:0] out_data
);
	i2c_seq_pkg::pair_s s;
	i2c_seq_pkg::pair_s next_s;

	always_comb begin
		next_s = s;
		if (out_ready && s.valid[0]) begin
			next_s.data[0] = s.data[1];
			next_s.valid[0] = s.valid[1];
			next_s.valid[1] = 1'b0;
		end
		// writer honours room, so an entry is never overwritten
		if (in_valid && s.room) begin
			if (!next_s.valid[0]) begin
				next_s.data[0] = in_data;
				next_s.valid[0] = 1'b1;
			end else begin
				next_s.data[1] = in_data;
				next_s.valid[1] = 1'b1;
			end
		end
		next_s.room = !next_s.valid[1];
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			s <= '{data: '0, valid: 2'h0, room: 1'b1};
		end else if (clock_enable) begin
			s <= next_s;
		end
	end

	assign in_ready = s.room;
	assign out_valid = s.valid[0];
	assign out_data = s.data[0];
endmodule : byte_pair_buffer

/* File: i2c_master_sequencer.sv */
`timescale 1ns/100ps
`include "i2c_master_sequencer_regs.svh"
module i2c_master_sequencer (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clock_enable,
	input wire logic [6:0] baud_reload_register,
	input wire logic begin_request_set,
	input wire logic repeat_begin_request_set,
	input wire logic receive_request_set,
	input wire logic buffer_write,
	input wire logic [7:0] buffer_write_data,
	input wire logic buffer_read,
	input wire logic write_collision_clear,
	input wire logic bus_collision_clear,
	input wire logic port_interrupt_clear,
	input wire logic receive_overrun_clear,
	input wire logic start_detected_clear,
	input wire logic bus_clock_line_in,
	output logic bus_clock_line_out,
	output logic bus_clock_line_oe,
	input wire logic bus_data_line_in,
	output logic bus_data_line_out,
	output logic bus_data_line_oe,
	output logic [7:0] transfer_buffer,
	output logic begin_request_bit,
	output logic repeat_begin_request_bit,
	output logic receive_request_bit,
	output logic buffer_full_flag,
	output logic write_collision_flag,
	output logic bus_collision_flag,
	output logic port_interrupt_flag,
	output logic ack_received_status,
	output logic receive_overrun_flag,
	output logic start_detected,
	output logic busy,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data
);
	i2c_seq_pkg::seq_s s;
	i2c_seq_pkg::seq_s next_s;
	logic rx_room;

	// level placed on data for a bit slot: 1 means release
	function automatic logic tx_level(input logic [7:0] value, input logic [3:0] slot);
		tx_level = (slot > `LAST_DATA_BIT) ? 1'b1 : value[3'(`LAST_DATA_BIT - slot)];
	endfunction : tx_level

	function automatic logic in_transmit(input i2c_seq_pkg::seq_state_e st);
		in_transmit = (st == i2c_seq_pkg::TX_LOW) || (st == i2c_seq_pkg::TX_HIGH_WAIT)
			|| (st == i2c_seq_pkg::TX_HIGH);
	endfunction : in_transmit

	// aborted sequence releases both lines and drops its request bits
	function automatic i2c_seq_pkg::seq_s collide(input i2c_seq_pkg::seq_s x);
		i2c_seq_pkg::seq_s y;
		y = x;
		y.bus_collision_flag = 1'b1;
		y.begin_request_bit = 1'b0;
		y.repeat_begin_request_bit = 1'b0;
		y.clock_oe = 1'b0;
		y.data_oe = 1'b0;
		y.state = i2c_seq_pkg::IDLE;
		collide = y;
	endfunction : collide

	always_comb begin
		logic tick;
		logic timeout;
		logic clock_high;
		logic data_high;
		logic [3:0] next_bit;
		tick = (s.phase == `HALF_INSTRUCTION_CLKS - 3'h1);
		timeout = tick && (s.baud_counter == 7'h00);
		clock_high = s.clock_sync_b;
		data_high = s.data_sync_b;
		next_s = s;
		next_bit = s.bit_count + 4'h1;
		// first stage feeds only the second
		next_s.clock_sync_a = bus_clock_line_in;
		next_s.clock_sync_b = s.clock_sync_a;
		next_s.data_sync_a = bus_data_line_in;
		next_s.data_sync_b = s.data_sync_a;
		next_s.data_prev = s.data_sync_b;
		next_s.push = 1'b0;

		if (tick) begin
			next_s.phase = 3'h0;
		end else begin
			next_s.phase = s.phase + 3'h1;
		end
		if (tick && s.baud_counter != 7'h00) begin
			next_s.baud_counter = s.baud_counter - 7'h01;
		end
		if (s.write_age != `COLLISION_WINDOW_CLKS) begin
			next_s.write_age = s.write_age + 5'h01;
		end

		// clears first, so a set in the same cycle wins
		if (write_collision_clear) begin
			next_s.write_collision_flag = 1'b0;
		end
		if (bus_collision_clear) begin
			next_s.bus_collision_flag = 1'b0;
		end
		if (port_interrupt_clear) begin
			next_s.port_interrupt_flag = 1'b0;
		end
		if (receive_overrun_clear) begin
			next_s.receive_overrun_flag = 1'b0;
		end
		if (start_detected_clear) begin
			next_s.start_detected = 1'b0;
		end
		if (buffer_read && !in_transmit(s.state)) begin
			next_s.buffer_full_flag = 1'b0;
		end
		// start seen on the lines, whoever made it
		if (s.data_prev && !data_high && clock_high) begin
			next_s.start_detected = 1'b1;
		end

		case (s.state)
			i2c_seq_pkg::IDLE: begin
				// requests only taken here, so nothing queues behind a sequence
				if (begin_request_set) begin
					if (clock_high && data_high) begin
						next_s.begin_request_bit = 1'b1;
						next_s.baud_counter = baud_reload_register;
						next_s.state = i2c_seq_pkg::START_WAIT;
					end else begin
						next_s = collide(next_s);
					end
				end else if (repeat_begin_request_set) begin
					next_s.repeat_begin_request_bit = 1'b1;
					next_s.clock_oe = 1'b1;
					next_s.state = i2c_seq_pkg::REPEAT_CLOCK_LOW;
				end else if (receive_request_set) begin
					next_s.receive_request_bit = 1'b1;
					next_s.bit_count = 4'h0;
					next_s.clock_oe = 1'b1;
					next_s.data_oe = 1'b0;
					next_s.baud_counter = baud_reload_register;
					next_s.state = i2c_seq_pkg::RX_LOW;
				end else if (buffer_write) begin
					next_s.transfer_buffer = buffer_write_data;
					next_s.buffer_full_flag = 1'b1;
					next_s.write_age = 5'h00;
					next_s.bit_count = 4'h0;
					next_s.clock_oe = 1'b1;
					next_s.data_oe = !tx_level(buffer_write_data, 4'h0);
					next_s.baud_counter = baud_reload_register;
					next_s.state = i2c_seq_pkg::TX_LOW;
				end
			end
			i2c_seq_pkg::START_WAIT: begin
				if (!clock_high) begin
					next_s = collide(next_s);
				end else if (timeout) begin
					if (data_high) begin
						next_s.data_oe = 1'b1;
						next_s.baud_counter = baud_reload_register;
						next_s.state = i2c_seq_pkg::START_HOLD;
					end else begin
						next_s = collide(next_s);
					end
				end
			end
			i2c_seq_pkg::START_HOLD: begin
				if (timeout) begin
					// counter left at zero: suspended, data stays low
					next_s.begin_request_bit = 1'b0;
					next_s.port_interrupt_flag = 1'b1;
					next_s.state = i2c_seq_pkg::IDLE;
				end
			end
			i2c_seq_pkg::REPEAT_CLOCK_LOW: begin
				if (!clock_high) begin
					next_s.data_oe = 1'b0;
					next_s.baud_counter = baud_reload_register;
					next_s.state = i2c_seq_pkg::REPEAT_DATA_RELEASE;
				end
			end
			i2c_seq_pkg::REPEAT_DATA_RELEASE: begin
				if (timeout) begin
					if (data_high) begin
						next_s.clock_oe = 1'b0;
						next_s.state = i2c_seq_pkg::REPEAT_CLOCK_RELEASE;
					end else begin
						next_s = collide(next_s);
					end
				end
			end
			i2c_seq_pkg::REPEAT_CLOCK_RELEASE: begin
				if (clock_high) begin
					if (!data_high) begin
						next_s = collide(next_s);
					end else begin
						next_s.baud_counter = baud_reload_register;
						next_s.state = i2c_seq_pkg::REPEAT_BOTH_HIGH;
					end
				end
			end
			i2c_seq_pkg::REPEAT_BOTH_HIGH: begin
				if (!clock_high) begin
					next_s = collide(next_s);
				end else if (timeout) begin
					next_s.data_oe = 1'b1;
					next_s.baud_counter = baud_reload_register;
					next_s.state = i2c_seq_pkg::REPEAT_DATA_LOW;
				end
			end
			i2c_seq_pkg::REPEAT_DATA_LOW: begin
				if (timeout) begin
					next_s.repeat_begin_request_bit = 1'b0;
					next_s.port_interrupt_flag = 1'b1;
					next_s.state = i2c_seq_pkg::IDLE;
				end
			end
			i2c_seq_pkg::TX_LOW: begin
				if (timeout) begin
					next_s.clock_oe = 1'b0;
					next_s.state = i2c_seq_pkg::TX_HIGH_WAIT;
				end
			end
			i2c_seq_pkg::TX_HIGH_WAIT: begin
				// a slave stretching the clock holds the count here
				if (clock_high) begin
					next_s.baud_counter = baud_reload_register;
					next_s.state = i2c_seq_pkg::TX_HIGH;
				end
			end
			i2c_seq_pkg::TX_HIGH: begin
				if (timeout) begin
					next_s.clock_oe = 1'b1;
					if (s.bit_count == `ACK_BIT) begin
						next_s.ack_received_status = data_high;
						next_s.port_interrupt_flag = 1'b1;
						next_s.state = i2c_seq_pkg::IDLE;
					end else begin
						if (s.bit_count == `LAST_DATA_BIT) begin
							next_s.buffer_full_flag = 1'b0;
						end
						next_s.bit_count = next_bit;
						next_s.data_oe = !tx_level(s.transfer_buffer, next_bit);
						next_s.baud_counter = baud_reload_register;
						next_s.state = i2c_seq_pkg::TX_LOW;
					end
				end
			end
			i2c_seq_pkg::RX_LOW: begin
				if (timeout) begin
					next_s.clock_oe = 1'b0;
					next_s.state = i2c_seq_pkg::RX_HIGH_WAIT;
				end
			end
			i2c_seq_pkg::RX_HIGH_WAIT: begin
				if (clock_high) begin
					next_s.shift_register = {s.shift_register[6:0], data_high};
					next_s.baud_counter = baud_reload_register;
					next_s.state = i2c_seq_pkg::RX_HIGH;
				end
			end
			i2c_seq_pkg::RX_HIGH: begin
				if (timeout) begin
					next_s.clock_oe = 1'b1;
					if (s.bit_count == `LAST_DATA_BIT) begin
						next_s.receive_request_bit = 1'b0;
						if (s.buffer_full_flag) begin
							next_s.receive_overrun_flag = 1'b1;
						end
						next_s.transfer_buffer = s.shift_register;
						next_s.buffer_full_flag = 1'b1;
						next_s.port_interrupt_flag = 1'b1;
						next_s.state = i2c_seq_pkg::RX_PUSH;
					end else begin
						next_s.bit_count = next_bit;
						next_s.baud_counter = baud_reload_register;
						next_s.state = i2c_seq_pkg::RX_LOW;
					end
				end
			end
			i2c_seq_pkg::RX_PUSH: begin
				// a full stream buffer stalls here, clock still held low
				if (rx_room) begin
					next_s.push = 1'b1;
					next_s.state = i2c_seq_pkg::IDLE;
				end
			end
			default: begin
				next_s.state = i2c_seq_pkg::IDLE;
			end
		endcase

		if (buffer_write && s.state != i2c_seq_pkg::IDLE) begin
			next_s.write_collision_flag = 1'b1;
			if (in_transmit(s.state) && s.write_age != `COLLISION_WINDOW_CLKS) begin
				next_s.transfer_buffer = buffer_write_data;
			end
		end
		next_s.busy = (next_s.state != i2c_seq_pkg::IDLE);
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			s <= '0;
		end else if (clock_enable) begin
			s <= next_s;
		end
	end

	byte_pair_buffer rx_stream (
		.clock(clock),
		.rst_b(rst_b),
		.clock_enable(clock_enable),
		.in_valid(s.push),
		.in_ready(rx_room),
		.in_data(s.transfer_buffer),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_data)
	);

	// open drain: output level fixed low, only the enable moves
	assign bus_clock_line_out = 1'b0;
	assign bus_data_line_out = 1'b0;
	assign bus_clock_line_oe = s.clock_oe;
	assign bus_data_line_oe = s.data_oe;
	assign transfer_buffer = s.transfer_buffer;
	assign begin_request_bit = s.begin_request_bit;
	assign repeat_begin_request_bit = s.repeat_begin_request_bit;
	assign receive_request_bit = s.receive_request_bit;
	assign buffer_full_flag = s.buffer_full_flag;
	assign write_collision_flag = s.write_collision_flag;
	assign bus_collision_flag = s.bus_collision_flag;
	assign port_interrupt_flag = s.port_interrupt_flag;
	assign ack_received_status = s.ack_received_status;
	assign receive_overrun_flag = s.receive_overrun_flag;
	assign start_detected = s.start_detected;
	assign busy = s.busy;
endmodule : i2c_master_sequencer

/* File: i2c_master_sequencer_checker.sv */
`timescale 1ns/100ps
module sequencer_checker (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [6:0] baud_reload_register,
	input wire logic begin_request_set,
	input wire logic repeat_begin_request_set,
	input wire logic receive_request_set,
	input wire logic buffer_write,
	input wire logic write_collision_clear,
	input wire logic bus_clock_line_in,
	input wire logic bus_clock_line_oe,
	input wire logic bus_data_line_oe,
	input wire logic begin_request_bit,
	input wire logic repeat_begin_request_bit,
	input wire logic receive_request_bit,
	input wire logic buffer_full_flag,
	input wire logic write_collision_flag,
	input wire logic bus_collision_flag,
	input wire logic port_interrupt_flag,
	input wire logic receive_overrun_flag,
	input wire logic busy
);
	logic [15:0] hi_cnt;
	logic any_req;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	assign any_req = begin_request_set | repeat_begin_request_set | receive_request_set | buffer_write;
	// cycles the clock line has read high, saturating
	always_ff @(posedge clock) begin
		if (!rst_b || !bus_clock_line_in) begin
			hi_cnt <= 16'h0000;
		end else if (hi_cnt != 16'hffff) begin
			hi_cnt <= hi_cnt + 16'h0001;
		end
	end
	high_phase_a: assert property ($rose(bus_clock_line_oe) && $past(busy)
		|-> hi_cnt >= {7'h00, baud_reload_register, 2'b00}) else $error("clock high too short");
	start_done_a: assert property ($fell(begin_request_bit) && !bus_collision_flag
		|-> port_interrupt_flag && bus_data_line_oe && !bus_clock_line_oe)
		else $error("start end wrong");
	start_write_a: assert property (buffer_write && begin_request_bit && busy
		|=> write_collision_flag) else $error("write in start");
	rx_refused_a: assert property (receive_request_set && busy && !receive_request_bit
		|=> !receive_request_bit) else $error("receive taken while busy");
	write_collision_flag_sticky_a: assert property (write_collision_flag && !write_collision_clear
		|=> write_collision_flag) else $error("write collision lost");
	rx_write_a: assert property (buffer_write && receive_request_bit && busy
		|=> write_collision_flag) else $error("write in receive");
	clock_held_a: assert property (!busy && bus_clock_line_oe && !any_req
		|=> bus_clock_line_oe) else $error("clock let go in idle");
	collision_abort_a: assert property ($rose(bus_collision_flag) |-> !busy && !bus_clock_line_oe
		&& !bus_data_line_oe && !begin_request_bit && !repeat_begin_request_bit)
		else $error("collision not aborted");
	overrun_cause_a: assert property ($rose(receive_overrun_flag) |-> $past(buffer_full_flag))
		else $error("overrun without full");
	cover property ($fell(begin_request_bit));
	cover property ($rose(receive_overrun_flag));
	cover property ($rose(bus_collision_flag));
endmodule : sequencer_checker
bind i2c_master_sequencer sequencer_checker sequencer_checker_i (.*);

/* File: bus_partner.sv */
`timescale 1ns/100ps
module bus_partner (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clock_oe,
	input wire logic data_oe,
	input wire logic send,
	input wire logic [7:0] send_byte,
	input wire logic ack,
	input wire logic stretch,
	input wire logic jam_data,
	output logic clock_line,
	output logic data_line
);
	logic prev_clock = 1'b1;
	logic prev_data = 1'b1;
	logic data_low = 1'b0;
	logic [3:0] rises = 4'h0;
	logic [5:0] hold = 6'h00;
	// pull-ups: a released or unknown drive reads high
	assign clock_line = !((clock_oe === 1'b1) || hold != 6'h00);
	assign data_line = !((data_oe === 1'b1) || jam_data || data_low);
	always_ff @(posedge clock) begin
		prev_clock <= clock_line;
		prev_data <= data_line;
		if (!rst_b) begin
			rises <= 4'h0;
			hold <= 6'h00;
			data_low <= 1'b0;
		end else begin
			// slow slave keeps clock low after each fall
			if (hold != 6'h00) begin
				hold <= hold - 6'h01;
			end else if (stretch && prev_clock && !clock_line) begin
				hold <= 6'h28;
			end
			if (clock_line && prev_data && !data_line) begin
				rises <= 4'h0;
			end else if (clock_line && !prev_clock) begin
				rises <= rises + 4'h1;
			end else if (!clock_line && (rises == 4'h9 || (send && rises == 4'h8))) begin
				rises <= 4'h0;
			end
			// data only moves while clock is low
			if (!clock_line) begin
				data_low <= send ? (rises < 4'h8 && !send_byte[3'h7 - rises[2:0]])
					: (ack && rises == 4'h8);
			end
		end
	end
endmodule : bus_partner

/* File: i2c_master_sequencer_bench.sv */
`timescale 1ns/100ps
module i2c_master_sequencer_bench;
	logic clock = 0, rst_b = 0, clock_enable = 1, rx_ready = 0;
	logic [6:0] baud_reload_register = 7'h01;
	logic [7:0] buffer_write_data = 8'h00, transfer_buffer, rx_data, send_byte = 8'h00;
	logic [9:0] pul = 10'h000;
	logic begin_request_set, repeat_begin_request_set, receive_request_set, buffer_write;
	logic buffer_read, write_collision_clear, bus_collision_clear, port_interrupt_clear;
	logic receive_overrun_clear, start_detected_clear, rx_valid, busy, start_detected;
	logic bus_clock_line_in, bus_clock_line_out, bus_clock_line_oe;
	logic bus_data_line_in, bus_data_line_out, bus_data_line_oe;
	logic begin_request_bit, repeat_begin_request_bit, receive_request_bit, buffer_full_flag;
	logic write_collision_flag, bus_collision_flag, port_interrupt_flag, ack_received_status;
	logic receive_overrun_flag, send = 0, ack = 0, stretch = 0, jam_data = 0, prev_clock = 1;
	logic [8:0] cap = 9'h000;
	logic [7:0] rxb [3] = '{8'hc3, 8'h81, 8'h7e};
	int n_mismatch = 0, checked = 0, cycles = 0, j;
	localparam logic [9:0] go_start = 10'h200, go_repeat = 10'h100, go_rx = 10'h080;
	localparam logic [9:0] go_wr = 10'h040, go_rd = 10'h020, clr_write_collision_flag = 10'h010;
	localparam logic [9:0] clr_flags = 10'h00f;
	assign {begin_request_set, repeat_begin_request_set, receive_request_set, buffer_write,
		buffer_read, write_collision_clear, bus_collision_clear, port_interrupt_clear,
		receive_overrun_clear, start_detected_clear} = pul;
	i2c_master_sequencer i2c_master_sequencer_i (.*);
	bus_partner bus_partner_i (.clock(clock), .rst_b(rst_b), .clock_oe(bus_clock_line_oe),
		.data_oe(bus_data_line_oe), .send(send), .send_byte(send_byte), .ack(ack),
		.stretch(stretch), .jam_data(jam_data), .clock_line(bus_clock_line_in),
		.data_line(bus_data_line_in));
	initial begin
		forever #5 clock = ~clock;
	end
	// wire bits as seen at each clock rise, last nine kept
	always @(posedge clock) begin
		prev_clock <= bus_clock_line_in;
		if (bus_clock_line_in && !prev_clock) begin
			cap <= {cap[7:0], bus_data_line_in};
		end
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			final_report;
		end
	end
	task automatic cmp1(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask : cmp1
	task automatic cmpv(input string what, input logic [8:0] exp, input logic [8:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : cmpv
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask : tick
	// one quiet edge after each strobe, so back to back calls never merge
	task automatic pulse(input logic [9:0] m);
		pul = m;
		@(negedge clock);
		pul = 10'h000;
		@(negedge clock);
	endtask : pulse
	task automatic write_byte(input logic [7:0] b);
		buffer_write_data = b;
		pulse(go_wr);
	endtask : write_byte
	// returns on idle or after a bound; callers judge busy themselves
	task automatic wait_idle;
		for (int i = 0; i < 3000 && busy !== 1'b0; i++) begin
			@(negedge clock);
		end
	endtask : wait_idle
	task automatic final_report;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	initial begin
		tick(4);
		rst_b = 1;
		tick(4);
		cmp1("idle_data_oe", 0, bus_data_line_oe);
		cmp1("line_out", 0, bus_clock_line_out | bus_data_line_out);
		pulse(go_start);
		write_byte(8'h99);
		cmp1("write_collision_flag_start", 1, write_collision_flag);
		cmpv("buffer_start", 9'h000, transfer_buffer);
		pulse(go_repeat);
		cmp1("repeat_bit", 0, repeat_begin_request_bit);
		wait_idle;
		cmp1("start_seen", 1, start_detected);
		cmp1("start_irq", 1, port_interrupt_flag);
		cmp1("start_data_oe", 1, bus_data_line_oe);
		cmp1("start_bit", 0, begin_request_bit);
		cmp1("write_collision_flag_kept", 1, write_collision_flag);
		pulse(clr_write_collision_flag | clr_flags);
		stretch = 1;
		write_byte(8'h5a);
		cmp1("full_tx", 1, buffer_full_flag);
		pulse(go_rx);
		cmp1("rx_bit_busy", 0, receive_request_bit);
		wait_idle;
		cmpv("wire_byte", 9'h0b5, cap);
		cmp1("nack", 1, ack_received_status);
		cmp1("tx_irq", 1, port_interrupt_flag);
		cmp1("tx_clock_held", 1, bus_clock_line_oe);
		cmp1("full_done", 0, buffer_full_flag);
		cmp1("tx_data_free", 0, bus_data_line_oe);
		ack = 1;
		write_byte(8'ha5);
		write_byte(8'h3c);
		cmp1("write_collision_flag_early", 1, write_collision_flag);
		cmpv("early_buffer", 9'h03c, transfer_buffer);
		pulse(clr_write_collision_flag);
		tick(100);
		write_byte(8'hff);
		cmp1("write_collision_flag_late", 1, write_collision_flag);
		cmpv("late_buffer", 9'h03c, transfer_buffer);
		wait_idle;
		cmp1("acked", 0, ack_received_status);
		pulse(clr_write_collision_flag | clr_flags);
		ack = 0;
		send = 1;
		for (int i = 0; i < 3; i++) begin
			send_byte = rxb[i];
			pulse(go_rx);
			if (i == 0) begin
				write_byte(8'h11);
				cmp1("write_collision_flag_rx", 1, write_collision_flag);
				cmpv("buffer_rx", 9'h03c, transfer_buffer);
			end
			wait_idle;
			cmpv("rx_buffer", {1'b0, rxb[i]}, transfer_buffer);
			cmp1("overrun", i > 0, receive_overrun_flag);
		end
		cmp1("rx_irq", 1, port_interrupt_flag);
		cmp1("rx_bit_done", 0, receive_request_bit);
		cmp1("rx_full", 1, buffer_full_flag);
		cmp1("stall_busy", 1, busy);
		rx_ready = 1;
		j = 0;
		repeat (40) begin
			if (rx_valid === 1'b1 && j < 3) begin
				cmpv("rx_stream", {1'b0, rxb[j]}, {1'b0, rx_data});
				j++;
			end
			@(negedge clock);
		end
		cmp1("all_drained", 1, j == 3);
		cmp1("drained_idle", 0, busy);
		pulse(go_rd);
		cmp1("full_read", 0, buffer_full_flag);
		send = 0;
		stretch = 0;
		pulse(clr_flags);
		pulse(go_repeat);
		wait_idle;
		cmp1("rs_seen", 1, start_detected);
		cmp1("rs_irq", 1, port_interrupt_flag);
		cmp1("rs_data_low", 1, bus_data_line_oe);
		cmp1("rs_clock_free", 0, bus_clock_line_oe);
		cmp1("rs_bit", 0, repeat_begin_request_bit);
		// frozen block must miss a request entirely
		clock_enable = 0;
		pulse(go_start);
		cmp1("frozen_start", 0, begin_request_bit);
		cmp1("frozen_busy", 0, busy);
		clock_enable = 1;
		jam_data = 1;
		for (int i = 0; i < 2; i++) begin
			pulse(clr_flags);
			pulse(i ? go_repeat : go_start);
			wait_idle;
			cmp1("collision", 1, bus_collision_flag);
			cmp1("collision_clock", 0, bus_clock_line_oe);
		end
		final_report;
	end
endmodule : i2c_master_sequencer_bench
